// file: hdl/adccal_consts.vh
// Purpose: constants for the converter configuration and calibration registers
// Assumes: AHB-Lite word map, one register per aligned word
// Notes:   offsets are register indices; byte address is four times the index
`ifndef ADCCAL_CONSTS_VH
`define ADCCAL_CONSTS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define ADCCAL_IDX_CFG        4'h2
`define ADCCAL_IDX_HPC_LO     4'h3
`define ADCCAL_IDX_HPC_HI     4'h4
`define ADCCAL_IDX_ZC0        4'h5
`define ADCCAL_IDX_ZC1        4'h6
`define ADCCAL_IDX_ZC2        4'h7
`define ADCCAL_IDX_SC0        4'h8
`define ADCCAL_IDX_SC1        4'h9
`define ADCCAL_IDX_SC2        4'ha
`define ADCCAL_IDX_AUX        4'hb
// own registers: conversion data in and corrected result out
`define ADCCAL_IDX_SAMPLE     4'hc
`define ADCCAL_IDX_RESULT     4'hd

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADCCAL_RST_CFG        8'h00
`define ADCCAL_RST_HPC_LO     8'h32
`define ADCCAL_RST_HPC_HI     8'h03
`define ADCCAL_RST_ZC         8'h00
`define ADCCAL_RST_SC0        8'h00
`define ADCCAL_RST_SC1        8'h00
`define ADCCAL_RST_SC2        8'h40

// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define ADCCAL_SEL_MSB        7
`define ADCCAL_SEL_LSB        5
`define ADCCAL_REF_MSB        4
`define ADCCAL_REF_LSB        3
`define ADCCAL_AMP_MSB        2
`define ADCCAL_AMP_LSB        0
`define ADCCAL_SEL_IN1        3'h0
`define ADCCAL_SEL_IN2        3'h1
`define ADCCAL_SEL_SHORT_R    3'h2
`define ADCCAL_SEL_BOTH       3'h3
`define ADCCAL_SEL_SHORT_0    3'h5
`define ADCCAL_REF_5V0        2'h0
`define ADCCAL_REF_4V096      2'h1
`define ADCCAL_REF_2V5        2'h2
`define ADCCAL_AMP_MAXGAIN    3'h6
`define ADCCAL_AMP_BUFFER     3'h7
`define ADCCAL_AUX1_LVL       4
`define ADCCAL_AUX0_LVL       3
`define ADCCAL_AUX1_DIR       2
`define ADCCAL_AUX0_DIR       1
`define ADCCAL_SCALE_SHIFT    22

`endif

// file: hdl/adccal_regs.v
// Purpose: configuration and calibration register bank with correction path
// Assumes: single-word AHB-Lite transfers, zero wait states, inputs synchronous
// Notes:   writes land at the end of the data phase; reads answer in that phase
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adccal_consts.vh"

module adccal_regs #(
  parameter DW = 32
) (
  // clock and reset
  input  wire          hclk,
  input  wire          hresetn,
  // ahb-lite slave
  input  wire          hsel,
  input  wire [11:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  // conversion path
  input  wire [DW-1:0] conv_data,
  input  wire          conv_valid,
  output reg  [DW-1:0] cal_data,
  output reg           cal_valid,
  // analog controls
  output reg  [2:0]    input_selector,
  output reg  [1:0]    ref_range,
  output reg  [2:0]    input_amplifier,
  output reg           amp_buffer_mode,
  output reg  [15:0]   highpass_corner_word,
  // aux pins
  input  wire [1:0]    aux_pin_in,
  output reg  [1:0]    aux_pin_out,
  output reg  [1:0]    aux_pin_oe
);

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  reg        wr_pend_q;
  reg [3:0]  wr_idx_q;
  wire       xfer = hsel & hready & htrans[1];
  wire [3:0] a_idx = haddr[5:2];
  wire       a_map = (haddr[11:6] == 6'h00);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 4'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= xfer & hwrite & a_map;
      wr_idx_q  <= a_idx;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0]    cfg_q, hpc_lo_q, hpc_hi_q;
  reg [7:0]    zc0_q, zc1_q, zc2_q, sc0_q, sc1_q, sc2_q;
  reg [1:0]    dir_q, lvl_q;
  reg [DW-1:0] sample_q;
  reg          sample_go_q;
  wire [7:0]   wb = hwdata[7:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q       <= `ADCCAL_RST_CFG;
      hpc_lo_q    <= `ADCCAL_RST_HPC_LO;
      hpc_hi_q    <= `ADCCAL_RST_HPC_HI;
      zc0_q       <= `ADCCAL_RST_ZC;
      zc1_q       <= `ADCCAL_RST_ZC;
      zc2_q       <= `ADCCAL_RST_ZC;
      sc0_q       <= `ADCCAL_RST_SC0;
      sc1_q       <= `ADCCAL_RST_SC1;
      sc2_q       <= `ADCCAL_RST_SC2;
      dir_q       <= 2'h0;
      sample_q    <= {DW{1'b0}};
      sample_go_q <= 1'b0;
    end else begin
      sample_go_q <= 1'b0;
      if (wr_pend_q) begin
        case (wr_idx_q)
          `ADCCAL_IDX_CFG:    cfg_q    <= wb;
          `ADCCAL_IDX_HPC_LO: hpc_lo_q <= wb;
          `ADCCAL_IDX_HPC_HI: hpc_hi_q <= wb;
          `ADCCAL_IDX_ZC0:    zc0_q    <= wb;
          `ADCCAL_IDX_ZC1:    zc1_q    <= wb;
          `ADCCAL_IDX_ZC2:    zc2_q    <= wb;
          `ADCCAL_IDX_SC0:    sc0_q    <= wb;
          `ADCCAL_IDX_SC1:    sc1_q    <= wb;
          `ADCCAL_IDX_SC2:    sc2_q    <= wb;
          // reserved bits are not stored, software keeps them zero
          `ADCCAL_IDX_AUX:    dir_q    <= {wb[`ADCCAL_AUX1_DIR], wb[`ADCCAL_AUX0_DIR]};
          `ADCCAL_IDX_SAMPLE: begin
            sample_q    <= hwdata[DW-1:0];
            sample_go_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // output latch of level bits; no reset, value is undefined until written
  reg [1:0] out_lvl_q;
  always @(posedge hclk) begin
    if (wr_pend_q && wr_idx_q == `ADCCAL_IDX_AUX)
      out_lvl_q <= {wb[`ADCCAL_AUX1_LVL], wb[`ADCCAL_AUX0_LVL]};
  end

  // pin level seen by software; output pins read back their own drive
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      lvl_q <= 2'h0;
    else
      lvl_q <= (dir_q & out_lvl_q) | (~dir_q & aux_pin_in);
  end

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_selector       <= `ADCCAL_SEL_IN1;
      ref_range            <= `ADCCAL_REF_5V0;
      input_amplifier      <= 3'h0;
      amp_buffer_mode      <= 1'b0;
      highpass_corner_word <= {`ADCCAL_RST_HPC_HI, `ADCCAL_RST_HPC_LO};
      aux_pin_out          <= 2'h0;
      aux_pin_oe           <= 2'h0;
    end else begin
      input_selector       <= cfg_q[`ADCCAL_SEL_MSB:`ADCCAL_SEL_LSB];
      ref_range            <= cfg_q[`ADCCAL_REF_MSB:`ADCCAL_REF_LSB];
      input_amplifier      <= cfg_q[`ADCCAL_AMP_MSB:`ADCCAL_AMP_LSB];
      amp_buffer_mode      <= (cfg_q[`ADCCAL_AMP_MSB:`ADCCAL_AMP_LSB] == `ADCCAL_AMP_BUFFER);
      highpass_corner_word <= {hpc_hi_q, hpc_lo_q};
      aux_pin_out          <= dir_q & out_lvl_q;
      aux_pin_oe           <= dir_q;
    end
  end

  // ----------------------------------------
  // correction: offset first, then gain
  // ----------------------------------------
  wire signed [23:0]    zero_word  = {zc2_q, zc1_q, zc0_q};
  wire        [23:0]    scale_word = {sc2_q, sc1_q, sc0_q};
  wire                  go         = conv_valid | sample_go_q;
  wire signed [DW-1:0]  din        = conv_valid ? conv_data : sample_q;
  // one guard bit keeps the subtraction from wrapping
  wire signed [DW:0]    diff       = {din[DW-1], din} - {{(DW-23){zero_word[23]}}, zero_word};
  wire signed [DW+25:0] prod       = diff * $signed({1'b0, scale_word});
  wire signed [DW+25:0] shifted    = prod >>> `ADCCAL_SCALE_SHIFT;
  // saturate rather than wrap when gain pushes past full scale
  wire signed [DW+25:0] maxv = {{27{1'b0}}, {(DW-1){1'b1}}};
  wire signed [DW+25:0] minv = ~maxv;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_data  <= {DW{1'b0}};
      cal_valid <= 1'b0;
    end else begin
      cal_valid <= go;
      if (go) begin
        if (shifted > maxv)
          cal_data <= maxv[DW-1:0];
        else if (shifted < minv)
          cal_data <= minv[DW-1:0];
        else
          cal_data <= shifted[DW-1:0];
      end
    end
  end

  // ----------------------------------------
  // read data, answered in the data phase
  // ----------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (a_map) begin
      case (a_idx)
        `ADCCAL_IDX_CFG:    rd_d[7:0] = cfg_q;
        `ADCCAL_IDX_HPC_LO: rd_d[7:0] = hpc_lo_q;
        `ADCCAL_IDX_HPC_HI: rd_d[7:0] = hpc_hi_q;
        `ADCCAL_IDX_ZC0:    rd_d[7:0] = zc0_q;
        `ADCCAL_IDX_ZC1:    rd_d[7:0] = zc1_q;
        `ADCCAL_IDX_ZC2:    rd_d[7:0] = zc2_q;
        `ADCCAL_IDX_SC0:    rd_d[7:0] = sc0_q;
        `ADCCAL_IDX_SC1:    rd_d[7:0] = sc1_q;
        `ADCCAL_IDX_SC2:    rd_d[7:0] = sc2_q;
        `ADCCAL_IDX_AUX:    rd_d[7:0] = {3'h0, lvl_q, dir_q, 1'b0};
        `ADCCAL_IDX_SAMPLE: rd_d[DW-1:0] = sample_q;
        `ADCCAL_IDX_RESULT: rd_d[DW-1:0] = cal_data;
        default:            rd_d = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (xfer && !hwrite)
      hrdata <= rd_d;
  end

endmodule // adccal_regs
`default_nettype wire

// file: test/adccal_regs_checker.sv
// Purpose: port-level checks on the calibration register bank
// Assumes: zero-wait bus; controls follow registers one cycle late
// Notes:   bound to adccal_regs
`timescale 1ns/1ps
`default_nettype none
module adccal_regs_checker #(
  parameter DW = 32
) (
  // clock, reset and bus
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hsel,
  input wire logic [11:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [2:0]    hsize,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic [31:0]   hrdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  // conversion path and controls
  input wire logic [DW-1:0] conv_data,
  input wire logic          conv_valid,
  input wire logic [DW-1:0] cal_data,
  input wire logic          cal_valid,
  input wire logic [2:0]    input_selector,
  input wire logic [1:0]    ref_range,
  input wire logic [2:0]    input_amplifier,
  input wire logic          amp_buffer_mode,
  input wire logic [15:0]   highpass_corner_word,
  input wire logic [1:0]    aux_pin_in,
  input wire logic [1:0]    aux_pin_out,
  input wire logic [1:0]    aux_pin_oe
);
  // ----------------------------------------
  // data phase tracking
  // ----------------------------------------
  logic       wr_q;
  logic [3:0] idx_q;
  wire        rd_take = hsel & hready & htrans[1] & ~hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      idx_q <= 4'h0;
    end else begin
      wr_q  <= hsel & hready & htrans[1] & hwrite;
      idx_q <= haddr[5:2];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_cfg_fields: assert property (wr_q && idx_q == 4'h2 |-> ##2
    {input_selector, ref_range, input_amplifier} == $past(hwdata[7:0], 2)) else $error("config fields wrong");
  a_buf_mode: assert property (amp_buffer_mode == (input_amplifier == 3'h7))
    else $error("buffer mode wrong");
  a_corner_lo: assert property (wr_q && idx_q == 4'h3 |-> ##2
    highpass_corner_word[7:0] == $past(hwdata[7:0], 2)) else $error("corner low byte wrong");
  a_dir_oe: assert property (wr_q && idx_q == 4'hb |-> ##2 aux_pin_oe == $past(hwdata[2:1], 2))
    else $error("pin direction wrong");
  a_cal_pulse: assert property (conv_valid |=> cal_valid) else $error("no corrected sample");
  a_cfg_readback: assert property (rd_take && haddr == 12'h008 |=>
    hrdata == {24'h0, input_selector, ref_range, input_amplifier}) else $error("config read wrong");
  a_rd_hold: assert property (!rd_take |=> $stable(hrdata)) else $error("read data moved");
  c_cal: cover property (cal_valid);
  c_aux_wr: cover property (wr_q && idx_q == 4'hb);
  c_res_rd: cover property (rd_take && haddr[5:2] == 4'hd);
endmodule // adccal_regs_checker

bind adccal_regs adccal_regs_checker #(.DW(DW)) adccal_regs_checker_inst (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .conv_data, .conv_valid,
  .cal_data, .cal_valid, .input_selector, .ref_range, .input_amplifier, .amp_buffer_mode,
  .highpass_corner_word, .aux_pin_in, .aux_pin_out, .aux_pin_oe);
`default_nettype wire

// file: test/adccal_regs_tb.sv
// Purpose: register and correction tests over the bus
// Assumes: one bus master, hready looped from hreadyout
// Notes:   word size only, so hsize stays tied
`timescale 1ns/1ps
`default_nettype none
module adccal_regs_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, conv_valid = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0, aux_pin_in = 2'h2;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, conv_data = 32'h0, rv, ev;
  wire  [31:0] hrdata, cal_data;
  wire         hreadyout, hresp, cal_valid, amp_buffer_mode;
  wire  [2:0]  input_selector, input_amplifier;
  wire  [1:0]  ref_range, aux_pin_out, aux_pin_oe;
  wire  [15:0] highpass_corner_word;
  int          n_fail = 0, comparisons = 0;
  logic [7:0]  rst_tbl [0:8] = '{8'h00, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  logic [2:0]  sel_tbl [0:4] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};

  adccal_regs #(.DW(32)) adccal_regs_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .conv_data, .conv_valid, .cal_data,
    .cal_valid, .input_selector, .ref_range, .input_amplifier, .amp_buffer_mode, .highpass_corner_word,
    .aux_pin_in, .aux_pin_out, .aux_pin_oe);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {6'h00, idx, 2'h0};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  // offset bytes low address first, gain likewise
  task automatic setcal(input logic [23:0] off, input logic [23:0] gn);
    for (int j = 0; j < 3; j++) begin
      xfer(1'b1, 4'(5 + j), {24'h0, off[8*j +: 8]});
      xfer(1'b1, 4'(8 + j), {24'h0, gn[8*j +: 8]});
    end
    @(posedge hclk);
  endtask
  task automatic cal(input logic [31:0] d, input logic [31:0] exp);
    conv_valid <= 1'b1;
    conv_data  <= d;
    @(posedge hclk);
    conv_valid <= 1'b0;
    // pulse lasts one cycle only, so look at it mid-cycle
    @(negedge hclk);
    chk("cal valid", {31'h0, cal_valid}, 32'h1);
    chk("cal data", cal_data, exp);
    @(posedge hclk);
  endtask
  task automatic close_out;
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial forever #12.5 hclk = ~hclk;
  initial begin
    repeat (5000) @(posedge hclk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("corner reset", {16'h0, highpass_corner_word}, 32'h0332);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, 4'(i + 2), 32'h0);
      chk("reset value", rv, {24'h0, rst_tbl[i]});
    end
    xfer(1'b0, 4'hb, 32'h0);
    chk("aux reset", rv & 32'hffffffe7, 32'h0);
    for (int i = 0; i < 8; i++) begin
      ev = {24'h0, sel_tbl[i % 5], 2'(i % 3), 3'(i)};
      xfer(1'b1, 4'h2, ev);
      xfer(1'b0, 4'h2, 32'h0);
      chk("cfg read", rv, ev);
      chk("controls", {24'h0, input_selector, ref_range, input_amplifier}, ev);
      chk("buffer", {31'h0, amp_buffer_mode}, {31'h0, i == 7});
    end
    xfer(1'b1, 4'h3, 32'ha5);
    xfer(1'b1, 4'h4, 32'h5a);
    repeat (2) @(posedge hclk);
    chk("corner word", {16'h0, highpass_corner_word}, 32'h5aa5);
    // gain first would give 53 and -3, so order shows
    setcal(24'hfffffd, 24'h200000);
    cal(32'd101, 32'd52);
    cal(32'hfffffff5, 32'hfffffffc);
    setcal(24'h000005, 24'hc00000);
    cal(32'd20, 32'd45);
    xfer(1'b1, 4'hc, 32'd25);
    repeat (3) @(posedge hclk);
    xfer(1'b0, 4'hd, 32'h0);
    chk("result reg", rv, 32'd60);
    // pins held opposite to the driven values
    xfer(1'b1, 4'hb, 32'h0e);
    repeat (2) @(posedge hclk);
    chk("aux drive", {28'h0, aux_pin_oe, aux_pin_out}, 32'hd);
    xfer(1'b0, 4'hb, 32'h0);
    chk("aux read out", rv, 32'h0e);
    xfer(1'b1, 4'hb, 32'h00);
    aux_pin_in <= 2'h1;
    repeat (3) @(posedge hclk);
    xfer(1'b0, 4'hb, 32'h0);
    chk("aux read in", rv, 32'h08);
    chk("aux released", {30'h0, aux_pin_oe}, 32'h0);
    xfer(1'b1, 4'h1, 32'hff);
    xfer(1'b0, 4'h1, 32'h0);
    chk("unmapped", rv, 32'h0);
    close_out();
  end
endmodule // adccal_regs_tb
`default_nettype wire
